// file: core_side_model.sv
`timescale 1ns/10ps
// ------------------------------------
// Watchdog oscillator and debugger bit
// ------------------------------------
module core_side_model #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dbg_set,
  input wire logic debug_req_clear,
  output logic osc_tick,
  output logic debug_reset_req
);
  int div_cnt;
  // Free-running after rstn, so tick phase is unrelated to later reset events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 0;
      osc_tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
      osc_tick <= (div_cnt == DIV - 1);
    end
  end
  // Request stays up until the device acknowledges it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debug_reset_req <= 1'b0;
    end else if (dbg_set) begin
      debug_reset_req <= 1'b1;
    end else if (debug_req_clear) begin
      debug_reset_req <= 1'b0;
    end
  end
endmodule

// file: reset_stop_recovery_ctrl.sv
`timescale 1ns/10ps
// Contract
// RULE1 - Brown-out below threshold holds device in reset
// RULE2 - After brown-out, full reset then power flag
// RULE3 - Keepalive bit keeps brown-out monitor on in STOP
// RULE4 - Watchdog time-out resets when reset-select is 1
// RULE5 - Watchdog reset sets watchdog cause flag
// RULE6 - Pin low four clocks qualifies reset
// RULE7 - Stay reset while pin low; exit on release
// RULE8 - Pin reset sets pin cause flag
// RULE9 - Debugger request resets all except debugger
// RULE10 - Debugger request bit self-clears during reset
// RULE11 - Debugger reset sets power flag
// RULE12 - Recovery holds core 66 osc plus 16 clocks
// RULE13 - Recovery touches only watchdog control flags
// RULE14 - Core fetches start vector at 0002H/0003H
// RULE15 - Recovery end sets stop flag
// RULE16 - Watchdog in STOP recovers, sets both, interrupt after
// RULE17 - Enabled wake pin edge in STOP recovers
// RULE18 - Input data gated in STOP; capture if level persists
// RULE19 - STOP halts oscillator, clock, core; drives crystal pins
// RULE20 - HALT stops core only; clocks keep running
// RULE21 - HALT exits on interrupt, watchdog, power, pin
// RULE22 - System reset counts 66 osc then 16 clocks
// RULE23 - Power events outrank all other sources
// RULE24 - Synchronise asynchronous reset and wake sources
module reset_stop_recovery_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire logic supply_low,
  input wire logic reset_pin_n,
  input wire logic debug_reset_req,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_select,
  input wire logic brownout_stop_keepalive,
  input wire logic watchdog_enable,
  input wire logic irq_pending,
  input wire logic irq_enable,
  input wire logic stop_cmd,
  input wire logic halt_cmd,
  input wire logic [rst_pkg::WAKE_PINS-1:0] wake_enable,
  input wire logic [rst_pkg::WAKE_PINS-1:0] gpio_in,
  input wire logic flags_clear,
  output logic core_reset,
  output logic periph_reset,
  output logic debugger_reset,
  output logic core_run,
  output logic periph_run,
  output logic sys_clk_en,
  output logic xtal_osc_en,
  output logic xtal_in_hi,
  output logic xtal_out_lo,
  output logic brownout_monitor,
  output logic debug_req_clear,
  output logic watchdog_irq_service,
  output logic port_input_sample,
  output logic [rst_pkg::WAKE_PINS-1:0] port_input_data,
  output logic [15:0] start_vector_addr,
  output logic power_on_flag,
  output logic watchdog_cause_flag,
  output logic pin_reset_cause_flag,
  output logic stop_flag
);
  import rst_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [WAKE_PINS+2:0] raw_in;
  logic [WAKE_PINS+2:0] sync_in;
  logic sup_low_s;
  logic pin_low_s;
  logic dbg_s;
  logic [WAKE_PINS-1:0] gpio_s;

  assign raw_in = {gpio_in, debug_reset_req, ~reset_pin_n, supply_low};
  sync2 #(.W(WAKE_PINS + 3)) u_sync ( // [RULE24]
    .clk(clk),
    .rstn(rstn),
    .d(raw_in),
    .q(sync_in)
  );
  assign sup_low_s = sync_in[0];
  assign pin_low_s = sync_in[1];
  assign dbg_s = sync_in[2];
  assign gpio_s = sync_in[WAKE_PINS+2:3];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_e state, next_state;
  logic [6:0] cnt, next_cnt;
  logic [2:0] filt, next_filt;
  logic [1:0] cause, next_cause;
  logic is_recovery, next_is_recovery;
  logic wdog_irq_pend, next_wdog_irq_pend;
  logic [WAKE_PINS-1:0] wake_ref, next_wake_ref;
  logic [WAKE_PINS-1:0] pdata, next_pdata;
  logic pin_ok;
  logic wake_edge;
  logic bo_active;
  logic n_core_reset, n_periph_reset, n_dbg_reset, n_core_run, n_periph_run;
  logic n_sys_clk, n_xtal, n_xin_hi, n_xout_lo, n_bo, n_dbg_clr, n_irq_srv, n_sample;
  logic n_por, n_wdf, n_pinf, n_stopf;
  logic [15:0] n_vec;

  // Pin counts as asserted only after the filter saturates
  assign pin_ok = (filt == 3'(PIN_FILTER_CYCLES)); // [RULE6]
  assign wake_edge = |((gpio_s ^ wake_ref) & wake_enable); // [RULE17]
  // Brown-out monitor is off in STOP unless kept alive
  assign bo_active = (state != ST_STOP) || brownout_stop_keepalive; // [RULE3]

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cause = cause;
    next_is_recovery = is_recovery;
    next_wdog_irq_pend = wdog_irq_pend;
    next_wake_ref = wake_ref;
    next_pdata = pdata;
    next_filt = pin_low_s ? ((filt == 3'(PIN_FILTER_CYCLES)) ? filt : filt + 3'h1) : 3'h0;
    n_por = power_on_flag;
    n_wdf = watchdog_cause_flag;
    n_pinf = pin_reset_cause_flag;
    n_stopf = stop_flag;
    if (flags_clear) begin
      n_por = 1'b0;
      n_wdf = 1'b0;
      n_pinf = 1'b0;
      n_stopf = 1'b0;
    end
    if (sup_low_s && bo_active) begin
      // Power wins unless the monitor is off in STOP, and restarts the full sequence
      next_state = ST_OSC_COUNT; // [RULE1] [RULE23]
      next_cnt = '0;
      next_cause = CAUSE_POWER;
      next_is_recovery = 1'b0;
    end else if (pin_ok && state != ST_OSC_COUNT && state != ST_SYS_COUNT && state != ST_PIN_HOLD) begin
      next_state = ST_OSC_COUNT; // [RULE6] [RULE21]
      next_cnt = '0;
      next_cause = CAUSE_PIN;
      next_is_recovery = 1'b0;
    end else begin
      case (state)
        ST_RUN, ST_HALT: begin
          if (dbg_s) begin
            next_state = ST_OSC_COUNT; // [RULE9]
            next_cnt = '0;
            next_cause = CAUSE_POWER;
            next_is_recovery = 1'b0;
          end else if (watchdog_timeout && watchdog_enable && watchdog_reset_select) begin
            next_state = ST_OSC_COUNT; // [RULE4] [RULE21]
            next_cnt = '0;
            next_cause = CAUSE_WDOG;
            next_is_recovery = 1'b0;
          end else if (state == ST_HALT && (irq_pending || (watchdog_timeout && watchdog_enable))) begin
            next_state = ST_RUN; // [RULE21]
          end else if (state == ST_RUN && stop_cmd) begin
            next_state = ST_STOP;
            next_wake_ref = gpio_s;
          end else if (state == ST_RUN && halt_cmd) begin
            next_state = ST_HALT;
          end
        end
        ST_STOP: begin
          if (watchdog_timeout && watchdog_enable) begin
            next_state = ST_OSC_COUNT; // [RULE16]
            next_cnt = '0;
            next_cause = CAUSE_WDOG;
            next_is_recovery = 1'b1;
            next_wdog_irq_pend = !watchdog_reset_select && irq_enable;
          end else if (wake_edge) begin
            next_state = ST_OSC_COUNT; // [RULE17]
            next_cnt = '0;
            next_cause = CAUSE_NONE;
            next_is_recovery = 1'b1;
          end
        end
        ST_OSC_COUNT: begin
          if (osc_tick) begin
            if (cnt == 7'(RESET_OSC_CYCLES - 1)) begin
              next_state = ST_SYS_COUNT; // [RULE12] [RULE22]
              next_cnt = '0;
            end else begin
              next_cnt = cnt + 7'h1;
            end
          end
        end
        ST_SYS_COUNT: begin
          if (cnt == 7'(RESET_SYS_CYCLES - 1)) begin
            next_cnt = '0;
            next_state = pin_low_s ? ST_PIN_HOLD : ST_RUN; // [RULE7]
          end else begin
            next_cnt = cnt + 7'h1;
          end
        end
        ST_PIN_HOLD: begin
          if (!pin_low_s) begin
            next_state = ST_RUN; // [RULE7]
          end
        end
        default: begin
          next_state = ST_OSC_COUNT;
          next_cnt = '0;
        end
      endcase
    end
    // Flags set on release; set beats a simultaneous clear
    if (next_state == ST_RUN && (state == ST_SYS_COUNT || state == ST_PIN_HOLD)) begin
      if (is_recovery) begin
        n_stopf = 1'b1; // [RULE15] [RULE13]
        if (cause == CAUSE_WDOG) begin
          n_wdf = 1'b1; // [RULE16]
        end
      end else begin
        n_por = n_por | (cause == CAUSE_POWER); // [RULE2] [RULE11]
        n_wdf = n_wdf | (cause == CAUSE_WDOG); // [RULE5]
        n_pinf = n_pinf | (cause == CAUSE_PIN); // [RULE8]
      end
      // Input data only latches levels that survived the recovery delay
      next_pdata = gpio_s; // [RULE18]
      next_is_recovery = 1'b0;
    end else if (state == ST_RUN || state == ST_HALT) begin
      next_pdata = gpio_s;
    end
    n_irq_srv = wdog_irq_pend && next_state == ST_RUN && state != ST_RUN; // [RULE16]
    if (n_irq_srv) begin
      next_wdog_irq_pend = 1'b0;
    end
    n_core_reset = (next_state == ST_OSC_COUNT || next_state == ST_SYS_COUNT || next_state == ST_PIN_HOLD);
    // Recovery leaves peripheral registers intact
    n_periph_reset = n_core_reset && !next_is_recovery; // [RULE13]
    n_dbg_reset = 1'b0; // [RULE9]
    n_dbg_clr = n_core_reset && dbg_s; // [RULE10]
    n_core_run = (next_state == ST_RUN); // [RULE20]
    n_periph_run = (next_state == ST_RUN || next_state == ST_HALT); // [RULE19] [RULE20]
    n_sys_clk = (next_state != ST_STOP && next_state != ST_OSC_COUNT); // [RULE19] [RULE22]
    n_xtal = (next_state != ST_STOP); // [RULE19]
    n_xin_hi = (next_state == ST_STOP);
    n_xout_lo = (next_state == ST_STOP);
    n_bo = (next_state != ST_STOP) || brownout_stop_keepalive; // [RULE3]
    n_sample = (next_state == ST_RUN || next_state == ST_HALT); // [RULE18]
    n_vec = n_core_reset ? START_VECTOR_LO_ADDR : start_vector_addr; // [RULE14]
    if (state == ST_SYS_COUNT || state == ST_PIN_HOLD) begin
      n_vec = (next_state == ST_RUN) ? START_VECTOR_HI_ADDR : START_VECTOR_LO_ADDR;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_OSC_COUNT;
      cnt <= '0;
      filt <= '0;
      cause <= CAUSE_POWER;
      is_recovery <= 1'b0;
      wdog_irq_pend <= 1'b0;
      wake_ref <= '0;
      pdata <= '0;
      core_reset <= 1'b1;
      periph_reset <= 1'b1;
      debugger_reset <= 1'b0;
      core_run <= 1'b0;
      periph_run <= 1'b0;
      sys_clk_en <= 1'b0;
      xtal_osc_en <= 1'b1;
      xtal_in_hi <= 1'b0;
      xtal_out_lo <= 1'b0;
      brownout_monitor <= 1'b1;
      debug_req_clear <= 1'b0;
      watchdog_irq_service <= 1'b0;
      port_input_sample <= 1'b0;
      port_input_data <= '0;
      start_vector_addr <= START_VECTOR_LO_ADDR;
      power_on_flag <= 1'b0;
      watchdog_cause_flag <= 1'b0;
      pin_reset_cause_flag <= 1'b0;
      stop_flag <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      filt <= next_filt;
      cause <= next_cause;
      is_recovery <= next_is_recovery;
      wdog_irq_pend <= next_wdog_irq_pend;
      wake_ref <= next_wake_ref;
      pdata <= next_pdata;
      core_reset <= n_core_reset;
      periph_reset <= n_periph_reset;
      debugger_reset <= n_dbg_reset;
      core_run <= n_core_run;
      periph_run <= n_periph_run;
      sys_clk_en <= n_sys_clk;
      xtal_osc_en <= n_xtal;
      xtal_in_hi <= n_xin_hi;
      xtal_out_lo <= n_xout_lo;
      brownout_monitor <= n_bo;
      debug_req_clear <= n_dbg_clr;
      watchdog_irq_service <= n_irq_srv;
      port_input_sample <= n_sample;
      port_input_data <= next_pdata;
      start_vector_addr <= n_vec;
      power_on_flag <= n_por;
      watchdog_cause_flag <= n_wdf;
      pin_reset_cause_flag <= n_pinf;
      stop_flag <= n_stopf;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_brownout_holds;
    @(posedge clk) disable iff (!rstn) (sup_low_s && bo_active) |=> core_reset;
  endproperty
  a_brownout_holds: assert property (p_brownout_holds) else $error("brown-out did not hold reset"); // [RULE1]

  property p_short_pin_ignored;
    @(posedge clk) disable iff (!rstn) (state == ST_RUN && !pin_low_s ##1 pin_low_s [*3] ##1 !pin_low_s)
      |=> (state == ST_RUN || state == ST_HALT || state == ST_STOP);
  endproperty
  a_short_pin_ignored: assert property (p_short_pin_ignored) else $error("short pin pulse caused reset"); // [RULE6]

  property p_pin_hold;
    @(posedge clk) disable iff (!rstn) (state == ST_PIN_HOLD && pin_low_s) |=> core_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("released while pin low"); // [RULE7]

  logic [4:0] sys_len, next_sys_len;

  // Counted apart from cnt, so a wrong terminal count still shows
  always_comb begin
    next_sys_len = (state == ST_SYS_COUNT) ? sys_len + 5'h1 : 5'h0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_len <= '0;
    end else begin
      sys_len <= next_sys_len;
    end
  end

  property p_sys_count_len;
    @(posedge clk) disable iff (!rstn)
      (state == ST_SYS_COUNT && (next_state == ST_RUN || next_state == ST_PIN_HOLD))
      |-> (sys_len == 5'(RESET_SYS_CYCLES - 1));
  endproperty
  a_sys_count_len: assert property (p_sys_count_len) else $error("system clock hold not 16 cycles"); // [RULE12]

  property p_stop_flag;
    @(posedge clk) disable iff (!rstn) (is_recovery && state == ST_SYS_COUNT && next_state == ST_RUN) |=> stop_flag;
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop flag not set"); // [RULE15]

  property p_pin_flag;
    @(posedge clk) disable iff (!rstn)
      (!is_recovery && cause == CAUSE_PIN && (state == ST_SYS_COUNT || state == ST_PIN_HOLD) && next_state == ST_RUN)
      |=> pin_reset_cause_flag;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin cause flag not set"); // [RULE8]

  property p_stop_clocks;
    @(posedge clk) disable iff (!rstn) (state == ST_STOP) |-> (!sys_clk_en && !xtal_osc_en && xtal_in_hi);
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clocks running in stop"); // [RULE19]

  property p_halt_clocks;
    @(posedge clk) disable iff (!rstn) (state == ST_HALT) |-> (sys_clk_en && periph_run && !core_run);
  endproperty
  a_halt_clocks: assert property (p_halt_clocks) else $error("halt clocks wrong"); // [RULE20]

  property p_recovery_keeps_periph;
    @(posedge clk) disable iff (!rstn) (is_recovery && state == ST_SYS_COUNT) |-> !periph_reset;
  endproperty
  a_recovery_keeps_periph: assert property (p_recovery_keeps_periph) else $error("recovery reset peripherals"); // [RULE13]

  c_stop_wake: cover property (@(posedge clk) disable iff (!rstn) state == ST_STOP ##1 state == ST_OSC_COUNT);
  c_halt_exit: cover property (@(posedge clk) disable iff (!rstn) state == ST_HALT ##1 state == ST_RUN);
  c_pin_hold: cover property (@(posedge clk) disable iff (!rstn) state == ST_PIN_HOLD ##1 state == ST_RUN);
endmodule

// file: rst_pkg.sv
package rst_pkg;
  localparam int CLK_MHZ = 200;
  localparam int RESET_OSC_CYCLES = 66;
  localparam int RESET_SYS_CYCLES = 16;
  localparam int PIN_FILTER_CYCLES = 4;
  localparam int WAKE_PINS = 8;
  localparam logic [15:0] START_VECTOR_LO_ADDR = 16'h0002;
  localparam logic [15:0] START_VECTOR_HI_ADDR = 16'h0003;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_POWER = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;
  localparam logic [1:0] CAUSE_PIN = 2'h3;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_HALT = 3'h1,
    ST_STOP = 3'h2,
    ST_OSC_COUNT = 3'h3,
    ST_SYS_COUNT = 3'h4,
    ST_PIN_HOLD = 3'h5
  } seq_state_e;
endpackage

// file: sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// file: tb_reset_stop_recovery_ctrl.sv
`timescale 1ns/10ps
module tb_reset_stop_recovery_ctrl;
  import rst_pkg::*;
  localparam int DIV = 4;
  // Tick phase is free, so the first counted tick may come early
  localparam int LO = (RESET_OSC_CYCLES - 1) * DIV + RESET_SYS_CYCLES;
  localparam int HI = RESET_OSC_CYCLES * DIV + RESET_SYS_CYCLES + 6;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic dbg_set = 1'b0;
  logic supply_low = 1'b0;
  logic reset_pin_n = 1'b1;
  logic watchdog_timeout = 1'b0;
  logic watchdog_reset_select = 1'b1;
  logic brownout_stop_keepalive = 1'b1;
  logic watchdog_enable = 1'b1;
  logic irq_pending = 1'b0;
  logic irq_enable = 1'b0;
  logic stop_cmd = 1'b0;
  logic halt_cmd = 1'b0;
  logic flags_clear = 1'b0;
  logic [WAKE_PINS-1:0] wake_enable = 8'h01;
  logic [WAKE_PINS-1:0] gpio_in = 8'h00;
  logic osc_tick, debug_reset_req, debug_req_clear;
  logic core_reset, periph_reset, debugger_reset, core_run, periph_run;
  logic sys_clk_en, xtal_osc_en, xtal_in_hi, xtal_out_lo, brownout_monitor;
  logic watchdog_irq_service, port_input_sample;
  logic [WAKE_PINS-1:0] port_input_data;
  logic [15:0] start_vector_addr;
  logic power_on_flag, watchdog_cause_flag, pin_reset_cause_flag, stop_flag;
  int mismatches = 0;
  int tests_run = 0;
  int irq_seen = 0;

  always #2.5 clk = ~clk;

  core_side_model #(.DIV(DIV)) i_core_side_model (
    .clk, .rstn, .dbg_set, .debug_req_clear, .osc_tick, .debug_reset_req
  );

  reset_stop_recovery_ctrl i_reset_stop_recovery_ctrl (
    .clk, .rstn, .osc_tick, .supply_low, .reset_pin_n, .debug_reset_req,
    .watchdog_timeout, .watchdog_reset_select, .brownout_stop_keepalive,
    .watchdog_enable, .irq_pending, .irq_enable, .stop_cmd, .halt_cmd,
    .wake_enable, .gpio_in, .flags_clear, .core_reset, .periph_reset,
    .debugger_reset, .core_run, .periph_run, .sys_clk_en, .xtal_osc_en,
    .xtal_in_hi, .xtal_out_lo, .brownout_monitor, .debug_req_clear,
    .watchdog_irq_service, .port_input_sample, .port_input_data,
    .start_vector_addr, .power_on_flag, .watchdog_cause_flag,
    .pin_reset_cause_flag, .stop_flag
  );

  always @(posedge clk) begin
    if (watchdog_irq_service === 1'b1) begin
      irq_seen++;
    end
  end

  // -------
  // Helpers
  // -------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fall(output int n);
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask

  // Entry within a few cycles, then the full hold length
  task automatic seq(string nm);
    int n;
    n = 0;
    while (core_reset !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk({nm, "_entry"}, 1, core_reset);
    chk({nm, "_vec"}, START_VECTOR_LO_ADDR, start_vector_addr);
    fall(n);
    chk({nm, "_vec_hi"}, START_VECTOR_HI_ADDR, start_vector_addr);
    chk({nm, "_len"}, 1, n >= LO && n <= HI);
    cyc(2);
  endtask

  task automatic clr();
    flags_clear = 1'b1;
    cyc(1);
    flags_clear = 1'b0;
    cyc(1);
  endtask

  task automatic pulse_wdt();
    watchdog_timeout = 1'b1;
    cyc(1);
    watchdog_timeout = 1'b0;
  endtask

  task automatic enter_mode(input logic stp);
    stop_cmd = stp;
    halt_cmd = !stp;
    cyc(1);
    stop_cmd = 1'b0;
    halt_cmd = 1'b0;
    cyc(3);
  endtask

  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    mismatches++;
    test_done();
  end

  // ---------
  // Sequence
  // ---------
  initial begin
    int n;
    cyc(2);
    rstn = 1'b1;
    seq("por");
    chk("por_flag", 1, power_on_flag);
    clr();
    reset_pin_n = 1'b0;
    cyc(PIN_FILTER_CYCLES - 1);
    reset_pin_n = 1'b1;
    cyc(8);
    chk("pin_short", 0, core_reset);
    reset_pin_n = 1'b0;
    cyc(PIN_FILTER_CYCLES);
    reset_pin_n = 1'b1;
    seq("pin_min");
    chk("pin_flag", 1, pin_reset_cause_flag);
    clr();
    reset_pin_n = 1'b0;
    cyc(HI + 50);
    chk("pin_held", 1, core_reset);
    chk("pin_periph", 1, periph_reset);
    reset_pin_n = 1'b1;
    fall(n);
    chk("pin_exit", 1, n <= 6);
    clr();
    watchdog_reset_select = 1'b0;
    pulse_wdt();
    cyc(8);
    chk("wdt_irqmode", 0, core_reset);
    watchdog_reset_select = 1'b1;
    pulse_wdt();
    seq("wdt");
    chk("wdt_flag", 1, watchdog_cause_flag);
    chk("wdt_pinflag", 0, pin_reset_cause_flag);
    clr();
    dbg_set = 1'b1;
    cyc(1);
    dbg_set = 1'b0;
    seq("dbg");
    chk("dbg_self", 0, debugger_reset);
    chk("dbg_bit", 0, debug_reset_req);
    chk("dbg_flag", 1, power_on_flag);
    clr();
    enter_mode(1'b1);
    chk("stop_clk", 0, sys_clk_en);
    chk("stop_xtal", 0, xtal_osc_en);
    chk("stop_xin", 1, xtal_in_hi);
    chk("stop_xout", 1, xtal_out_lo);
    chk("stop_core", 0, core_run);
    chk("stop_periph", 0, periph_run);
    chk("stop_bo_on", 1, brownout_monitor);
    chk("stop_sample", 0, port_input_sample);
    gpio_in = 8'h02;
    cyc(8);
    chk("wake_masked", 0, core_reset);
    gpio_in = 8'h03;
    seq("gpio");
    chk("gpio_stop", 1, stop_flag);
    chk("gpio_power", 0, power_on_flag);
    chk("gpio_data", 8'h03, port_input_data);
    chk("gpio_run", 1, core_run);
    clr();
    brownout_stop_keepalive = 1'b0;
    watchdog_reset_select = 1'b0;
    irq_enable = 1'b1;
    enter_mode(1'b1);
    chk("stop_bo_off", 0, brownout_monitor);
    irq_seen = 0;
    pulse_wdt();
    seq("wdt_stop");
    chk("ws_stop", 1, stop_flag);
    chk("ws_wdt", 1, watchdog_cause_flag);
    chk("ws_irq", 1, irq_seen);
    clr();
    enter_mode(1'b0);
    chk("halt_core", 0, core_run);
    chk("halt_clk", 1, sys_clk_en);
    chk("halt_xtal", 1, xtal_osc_en);
    chk("halt_periph", 1, periph_run);
    irq_pending = 1'b1;
    cyc(4);
    chk("halt_irq", 1, core_run);
    irq_pending = 1'b0;
    enter_mode(1'b0);
    supply_low = 1'b1;
    cyc(HI + 50);
    chk("bo_held", 1, core_reset);
    supply_low = 1'b0;
    fall(n);
    chk("bo_len", 1, n >= LO && n <= HI);
    chk("bo_flag", 1, power_on_flag);
    clr();
    watchdog_reset_select = 1'b1;
    pulse_wdt();
    cyc(100);
    supply_low = 1'b1;
    cyc(20);
    supply_low = 1'b0;
    fall(n);
    chk("bo_restart", 1, n >= LO);
    chk("bo_prio", 1, power_on_flag);
    test_done();
  end
endmodule
